//--- pcs_loader.sv
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps


module pcs_loader (
  input  wire logic                           clk_sys,
  input  wire logic                           reset_n,
  input  wire logic                           clk_en,
  // core step port
  input  wire logic                           step_valid,
  input  wire pcs_pkg::pcs_step_t             step_kind,
  input  wire logic [pcs_pkg::OPERAND_W-1:0]  step_operand,
  input  wire logic [pcs_pkg::LOW_W-1:0]      working_value,
  input  wire logic [pcs_pkg::LOW_W-1:0]      low_write_data,
  input  wire logic                           latch_write_en,
  input  wire logic [pcs_pkg::HIGH_W-1:0]     latch_write_data,
  output logic      [pcs_pkg::PC_W-1:0]       program_counter,
  // register bus
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [pcs_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  input  wire logic [pcs_pkg::DATA_W-1:0]     s_axi_wdata,
  input  wire logic [pcs_pkg::STRB_W-1:0]     s_axi_wstrb,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  output logic      [1:0]                     s_axi_bresp,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  input  wire logic [pcs_pkg::ADDR_W-1:0]     s_axi_araddr,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  output logic      [pcs_pkg::DATA_W-1:0]     s_axi_rdata,
  output logic      [1:0]                     s_axi_rresp
);

  // ***********************************************************************
  // declarations
  // ***********************************************************************
  logic [pcs_pkg::HIGH_W-1:0]      counter_high_latch;
  logic                            run_enable;
  logic                            stack_ovf_flag;
  logic                            stack_unf_flag;

  logic [pcs_pkg::ADDR_W-1:0]      wr_addr;
  logic [pcs_pkg::DATA_W-1:0]      wr_data;
  logic [pcs_pkg::STRB_W-1:0]      wr_strb;

  logic                            core_step;
  logic                            core_busy;
  logic                            aw_take;
  logic                            w_take;
  logic                            wr_commit;
  logic                            b_done;
  logic                            ar_take;
  logic                            r_done;

  logic                            hit_low_w;
  logic                            hit_latch_w;
  logic                            hit_ctrl_w;
  logic                            hit_stat_w;
  logic                            wr_mapped;
  logic                            low_lane;
  logic                            flag_lane;
  logic                            sw_low_load;
  logic                            sw_latch_load;
  logic                            sw_ctrl_load;
  logic                            sw_flag_clear;

  logic                            hit_low_r;
  logic                            hit_latch_r;
  logic                            hit_ctrl_r;
  logic                            hit_stat_r;
  logic                            rd_mapped;
  logic [pcs_pkg::DATA_W-1:0]      status_word;
  logic [pcs_pkg::DATA_W-1:0]      read_word;

  pcs_pkg::pcs_step_t              eff_kind;
  logic [pcs_pkg::LOW_W-1:0]       eff_low;
  logic [pcs_pkg::PC_W-1:0]        next_pc;
  logic [pcs_pkg::PC_W-1:0]        return_addr;
  logic [pcs_pkg::PC_W-1:0]        stack_top;
  logic [pcs_pkg::STACK_CNT_W-1:0] stack_depth;
  logic                            stack_push;
  logic                            stack_pop;
  logic                            ovf_event;
  logic                            unf_event;
  logic                            next_ovf_flag;
  logic                            next_unf_flag;

  // ***********************************************************************
  // step arbitration
  // ***********************************************************************
  // the core owns the counter; a bus write waits while the core is busy so
  // no instruction step is ever dropped in favour of a software write
  assign core_step = step_valid && run_enable && (step_kind != pcs_pkg::STEP_NONE);
  assign core_busy = core_step || latch_write_en;

  // a software low-byte write is fed through the same path as a core write
  assign eff_kind = core_step   ? step_kind :
                    sw_low_load ? pcs_pkg::STEP_WRITE_LOW : pcs_pkg::STEP_NONE;
  assign eff_low  = core_step ? low_write_data : wr_data[pcs_pkg::LOW_W-1:0];

  // ***********************************************************************
  // target selection and return stack
  // ***********************************************************************
  pcs_target_calc u_calc (
    .pc          (program_counter),
    .latch       (counter_high_latch),
    .kind        (eff_kind),
    .operand     (step_operand),
    .working     (working_value),
    .low_data    (eff_low),
    .stack_top   (stack_top),
    .next_pc     (next_pc),
    .return_addr (return_addr),
    .push        (stack_push),
    .pop         (stack_pop)
  );

  pcs_return_stack u_stack (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .push      (stack_push),
    .pop       (stack_pop),
    .push_data (return_addr),
    .top_data  (stack_top),
    .depth     (stack_depth),
    .overflow  (ovf_event),
    .underflow (unf_event)
  );

  // ***********************************************************************
  // program counter
  // ***********************************************************************
  // counter register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      program_counter <= pcs_pkg::PC_RESET;
    end else if (clk_en) begin
      program_counter <= next_pc;
    end
  end

  // latch register; core write has priority over the bus
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      counter_high_latch <= pcs_pkg::LATCH_RESET;
    end else if (clk_en && latch_write_en) begin
      counter_high_latch <= latch_write_data;
    end else if (clk_en && sw_latch_load) begin
      counter_high_latch <= wr_data[pcs_pkg::HIGH_W-1:0];
    end
  end

  // ***********************************************************************
  // control and sticky stack flags
  // ***********************************************************************
  // a stack event in the clearing cycle wins, so none is lost
  assign next_ovf_flag = ovf_event ||
                         (stack_ovf_flag && !(sw_flag_clear && wr_data[pcs_pkg::STAT_OVF_BIT]));
  assign next_unf_flag = unf_event ||
                         (stack_unf_flag && !(sw_flag_clear && wr_data[pcs_pkg::STAT_UNF_BIT]));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      run_enable     <= pcs_pkg::RUN_RESET;
      stack_ovf_flag <= 1'b0;
      stack_unf_flag <= 1'b0;
    end else if (clk_en) begin
      run_enable     <= sw_ctrl_load ? wr_data[pcs_pkg::CTRL_RUN_BIT] : run_enable;
      stack_ovf_flag <= next_ovf_flag;
      stack_unf_flag <= next_unf_flag;
    end
  end

  // ***********************************************************************
  // bus write channel
  // ***********************************************************************
  // address and data are held independently; commit once both are held
  assign aw_take   = s_axi_awvalid && s_axi_awready;
  assign w_take    = s_axi_wvalid && s_axi_wready;
  assign wr_commit = !s_axi_awready && !s_axi_wready && !s_axi_bvalid && !core_busy;
  assign b_done    = s_axi_bvalid && s_axi_bready;

  assign hit_low_w   = pcs_pkg::addr_hit(wr_addr, pcs_pkg::OFF_LOW_BYTE);
  assign hit_latch_w = pcs_pkg::addr_hit(wr_addr, pcs_pkg::OFF_HIGH_LATCH);
  assign hit_ctrl_w  = pcs_pkg::addr_hit(wr_addr, pcs_pkg::OFF_CONTROL);
  assign hit_stat_w  = pcs_pkg::addr_hit(wr_addr, pcs_pkg::OFF_STATUS);
  assign wr_mapped   = hit_low_w || hit_latch_w || hit_ctrl_w || hit_stat_w;
  assign low_lane    = wr_strb[pcs_pkg::STRB_LOW_LANE];
  assign flag_lane   = wr_strb[pcs_pkg::STRB_FLAG_LANE];

  // effects only happen on the lanes that hold the field
  assign sw_low_load   = wr_commit && hit_low_w && low_lane;
  assign sw_latch_load = wr_commit && hit_latch_w && low_lane;
  assign sw_ctrl_load  = wr_commit && hit_ctrl_w && low_lane;
  assign sw_flag_clear = wr_commit && hit_stat_w && flag_lane;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else if (clk_en) begin
      wr_addr <= aw_take ? s_axi_awaddr : wr_addr;
      wr_data <= w_take ? s_axi_wdata : wr_data;
      wr_strb <= w_take ? s_axi_wstrb : wr_strb;
    end
  end

  // readies drop on capture and return after the response is taken
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pcs_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= b_done ? 1'b1 : (s_axi_awready && !aw_take);
      s_axi_wready  <= b_done ? 1'b1 : (s_axi_wready && !w_take);
      s_axi_bvalid  <= wr_commit ? 1'b1 : (s_axi_bvalid && !b_done);
      s_axi_bresp   <= wr_commit ? (wr_mapped ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR)
                                 : s_axi_bresp;
    end
  end

  // ***********************************************************************
  // bus read channel
  // ***********************************************************************
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign r_done  = s_axi_rvalid && s_axi_rready;

  assign hit_low_r   = pcs_pkg::addr_hit(s_axi_araddr, pcs_pkg::OFF_LOW_BYTE);
  assign hit_latch_r = pcs_pkg::addr_hit(s_axi_araddr, pcs_pkg::OFF_HIGH_LATCH);
  assign hit_ctrl_r  = pcs_pkg::addr_hit(s_axi_araddr, pcs_pkg::OFF_CONTROL);
  assign hit_stat_r  = pcs_pkg::addr_hit(s_axi_araddr, pcs_pkg::OFF_STATUS);
  assign rd_mapped   = hit_low_r || hit_latch_r || hit_ctrl_r || hit_stat_r;

  // upper bits hidden: status carries only stack state, no counter bits
  assign status_word = {6'h00, stack_unf_flag, stack_ovf_flag, 3'h0, stack_depth,
                        16'h0000};

  // unused bits read as zero; the upper counter bits never appear here
  assign read_word = hit_low_r   ? {24'h000000, program_counter[pcs_pkg::LOW_W-1:0]} :
                     hit_latch_r ? {25'h0000000, counter_high_latch} :
                     hit_ctrl_r  ? {31'h00000000, run_enable} :
                     hit_stat_r  ? status_word : 32'h00000000;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= pcs_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= r_done ? 1'b1 : (s_axi_arready && !ar_take);
      s_axi_rvalid  <= ar_take ? 1'b1 : (s_axi_rvalid && !r_done);
      s_axi_rdata   <= ar_take ? read_word : s_axi_rdata;
      s_axi_rresp   <= ar_take ? (rd_mapped ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR)
                               : s_axi_rresp;
    end
  end

endmodule : pcs_loader

//--- pcs_pkg.sv
package pcs_pkg;

  // ***********************************************************************
  // widths of the counter and its operands
  // ***********************************************************************
  localparam int PC_W        = 15;
  localparam int LOW_W       = 8;
  localparam int HIGH_W      = 7;
  localparam int OPERAND_W   = 11;
  localparam int CALL_OP_W   = 11;
  localparam int BRI_OP_W    = 9;
  localparam int CALL_KEEP_W = PC_W - CALL_OP_W;

  // ***********************************************************************
  // return stack shape
  // ***********************************************************************
  localparam int STACK_DEPTH = 16;
  localparam int STACK_PTR_W = 4;
  localparam int STACK_CNT_W = 5;

  // ***********************************************************************
  // register bus geometry and map
  // ***********************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  localparam logic [ADDR_W-1:0] OFF_LOW_BYTE   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_HIGH_LATCH = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CONTROL    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h0C;

  // field positions
  localparam int CTRL_RUN_BIT   = 0;
  localparam int STAT_DEPTH_LSB = 16;
  localparam int STAT_OVF_BIT   = 24;
  localparam int STAT_UNF_BIT   = 25;
  localparam int STRB_LOW_LANE  = 0;
  localparam int STRB_FLAG_LANE = 3;

  // reset values
  localparam logic [PC_W-1:0]   PC_RESET    = 15'h0000;
  localparam logic [HIGH_W-1:0] LATCH_RESET = 7'h00;
  localparam logic              RUN_RESET   = 1'h1;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***********************************************************************
  // step kinds offered by the core each instruction
  // ***********************************************************************
  typedef enum logic [3:0] {
    STEP_NONE,
    STEP_ADVANCE,
    STEP_WRITE_LOW,
    STEP_ADD_LOW,
    STEP_CALL,
    STEP_CALL_W,
    STEP_BRANCH_W,
    STEP_BRANCH_IMM,
    STEP_RETURN
  } pcs_step_t;

  // counter plus one, wrapping at the full width
  function automatic logic [PC_W-1:0] pc_incr(input logic [PC_W-1:0] pc);
    pc_incr = pc + 15'h0001;
  endfunction : pc_incr

  // upper bits from the latch, low byte from the given value
  function automatic logic [PC_W-1:0] pc_join(input logic [HIGH_W-1:0] high,
                                               input logic [LOW_W-1:0]  low);
    pc_join = {high, low};
  endfunction : pc_join

  // word decode ignoring the two byte-offset bits
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] off);
    addr_hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction : addr_hit

endpackage : pcs_pkg

//--- pcs_target_calc.sv
`timescale 1ns/1ps

module pcs_target_calc (
  input  wire logic [pcs_pkg::PC_W-1:0]      pc,
  input  wire logic [pcs_pkg::HIGH_W-1:0]    latch,
  input  wire pcs_pkg::pcs_step_t            kind,
  input  wire logic [pcs_pkg::OPERAND_W-1:0] operand,
  input  wire logic [pcs_pkg::LOW_W-1:0]     working,
  input  wire logic [pcs_pkg::LOW_W-1:0]     low_data,
  input  wire logic [pcs_pkg::PC_W-1:0]      stack_top,
  output logic      [pcs_pkg::PC_W-1:0]      next_pc,
  output logic      [pcs_pkg::PC_W-1:0]      return_addr,
  output logic                               push,
  output logic                               pop
);

  logic [pcs_pkg::PC_W-1:0]  inc;
  logic [pcs_pkg::LOW_W-1:0] add_low;
  logic [pcs_pkg::PC_W-1:0]  t_write;
  logic [pcs_pkg::PC_W-1:0]  t_add;
  logic [pcs_pkg::PC_W-1:0]  t_call;
  logic [pcs_pkg::PC_W-1:0]  t_call_via_working_register;
  logic [pcs_pkg::PC_W-1:0]  t_brw;
  logic [pcs_pkg::PC_W-1:0]  t_bri;

  // ***********************************************************************
  // candidate targets
  // ***********************************************************************
  assign inc = pcs_pkg::pc_incr(pc);
  assign t_write = pcs_pkg::pc_join(latch, low_data);
  // no carry out: the byte sum is cut, so tables wrap inside their block
  assign add_low = inc[pcs_pkg::LOW_W-1:0] + working;
  assign t_add   = pcs_pkg::pc_join(latch, add_low);
  assign t_call  = {latch[pcs_pkg::HIGH_W-1:pcs_pkg::HIGH_W-pcs_pkg::CALL_KEEP_W],
                    operand[pcs_pkg::CALL_OP_W-1:0]};
  assign t_call_via_working_register = pcs_pkg::pc_join(latch, working);
  assign t_brw   = inc + {7'h00, working};
  assign t_bri   = inc + pcs_pkg::PC_W'(signed'(operand[pcs_pkg::BRI_OP_W-1:0]));

  assign return_addr = inc;

  // select by step kind; calls also push the return address
  always_comb begin
    next_pc = pc;
    push    = 1'b0;
    pop     = 1'b0;
    unique case (kind)
      pcs_pkg::STEP_NONE:       next_pc = pc;
      pcs_pkg::STEP_ADVANCE:    next_pc = inc;
      pcs_pkg::STEP_WRITE_LOW:  next_pc = t_write;
      pcs_pkg::STEP_ADD_LOW:    next_pc = t_add;
      pcs_pkg::STEP_CALL: begin
        next_pc = t_call;
        push    = 1'b1;
      end
      pcs_pkg::STEP_CALL_W: begin
        next_pc = t_call_via_working_register;
        push    = 1'b1;
      end
      pcs_pkg::STEP_BRANCH_W:   next_pc = t_brw;
      pcs_pkg::STEP_BRANCH_IMM: next_pc = t_bri;
      pcs_pkg::STEP_RETURN: begin
        next_pc = stack_top;
        pop     = 1'b1;
      end
      default:                  next_pc = pc;
    endcase
  end

endmodule : pcs_target_calc

//--- pcs_return_stack.sv
`timescale 1ns/1ps

module pcs_return_stack (
  input  wire logic                           clk_sys,
  input  wire logic                           reset_n,
  input  wire logic                           clk_en,
  input  wire logic                           push,
  input  wire logic                           pop,
  input  wire logic [pcs_pkg::PC_W-1:0]       push_data,
  output logic      [pcs_pkg::PC_W-1:0]       top_data,
  output logic      [pcs_pkg::STACK_CNT_W-1:0] depth,
  output logic                                overflow,
  output logic                                underflow
);

  logic [pcs_pkg::PC_W-1:0]        mem [pcs_pkg::STACK_DEPTH];
  logic [pcs_pkg::STACK_PTR_W-1:0] ptr;
  logic [pcs_pkg::STACK_PTR_W-1:0] top_ptr;
  logic                            full;
  logic                            empty;

  // ***********************************************************************
  // pointer and fill level
  // ***********************************************************************
  assign top_ptr   = ptr - 4'h1;
  assign top_data  = mem[top_ptr];
  assign full      = (depth == 5'h10);
  assign empty     = (depth == 5'h00);
  // pushing when full overwrites the oldest entry; the event is reported
  assign overflow  = push && full;
  assign underflow = pop && empty;

  // pointer wraps; depth saturates so software sees the true fill
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ptr   <= 4'h0;
      depth <= 5'h00;
    end else if (clk_en && push) begin
      ptr   <= ptr + 4'h1;
      depth <= full ? depth : depth + 5'h01;
    end else if (clk_en && pop) begin
      ptr   <= top_ptr;
      depth <= empty ? depth : depth - 5'h01;
    end
  end

  // entries are data only, so they carry no reset
  always_ff @(posedge clk_sys) begin
    if (clk_en && push) begin
      mem[ptr] <= push_data;
    end
  end

endmodule : pcs_return_stack

//--- pcs_loader_props.sv
`timescale 1ns/1ps
// ****************
// pc load checks
// ****************
module pcs_loader_props (
  input wire logic               clk_sys,
  input wire logic               reset_n,
  input wire logic               clk_en,
  input wire logic               step_valid,
  input wire pcs_pkg::pcs_step_t step_kind,
  input wire logic [10:0]        step_operand,
  input wire logic [7:0]         working_value,
  input wire logic [7:0]         low_write_data,
  input wire logic               latch_write_en,
  input wire logic [6:0]         latch_write_data,
  input wire logic [14:0]        program_counter,
  input wire logic               s_axi_bvalid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // latch copy follows the core port only; run is assumed never cleared
  logic [6:0]  lat;
  wire         tk = clk_en && step_valid;
  wire [7:0]   lo = program_counter[7:0] + 8'h01 + working_value;
  wire [14:0]  bw = program_counter + 15'h0001 + {7'h00, working_value};
  wire [14:0]  bi = program_counter + 15'h0001 + {{6{step_operand[8]}}, step_operand[8:0]};
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) lat <= 7'h00;
    else if (clk_en && latch_write_en) lat <= latch_write_data;
  end
  chk_reset_clear: assert property (disable iff (1'b0)
    !reset_n |-> program_counter == 15'h0000) else $error("pc not clear");
  chk_write_low: assert property (tk && step_kind == pcs_pkg::STEP_WRITE_LOW
    |=> program_counter == {$past(lat), $past(low_write_data)}) else $error("bad low write");
  chk_add_wrap: assert property (tk && step_kind == pcs_pkg::STEP_ADD_LOW
    |=> program_counter == {$past(lat), $past(lo)}) else $error("bad add");
  chk_call_direct: assert property (tk && step_kind == pcs_pkg::STEP_CALL
    |=> program_counter == {$past(lat[6:3]), $past(step_operand)}) else $error("bad call");
  chk_call_work: assert property (tk && step_kind == pcs_pkg::STEP_CALL_W
    |=> program_counter == {$past(lat), $past(working_value)}) else $error("bad call_via_working_register");
  chk_branch_work: assert property (tk && step_kind == pcs_pkg::STEP_BRANCH_W
    |=> program_counter == $past(bw)) else $error("bad branch w");
  chk_branch_imm: assert property (tk && step_kind == pcs_pkg::STEP_BRANCH_IMM
    |=> program_counter == $past(bi)) else $error("bad branch imm");
  chk_pc_hold: assert property (!tk
    |=> $stable(program_counter) || $rose(s_axi_bvalid)) else $error("pc moved");
endmodule : pcs_loader_props
bind pcs_loader pcs_loader_props chk_u (.*);

//--- tb_top.sv
`timescale 1ns/1ps
// ****************
// pc loader bench
// ****************
module tb_top;
  logic               clk_sys = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
  logic               step_valid = 1'b0, latch_write_en = 1'b0;
  pcs_pkg::pcs_step_t step_kind = pcs_pkg::STEP_NONE;
  logic [10:0]        step_operand = 11'h000;
  logic [7:0]         working_value = 8'h00, low_write_data = 8'h00;
  logic [7:0]         s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [6:0]         latch_write_data = 7'h00, m_lat = 7'h00;
  logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic               s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic [3:0]         s_axi_wstrb = 4'hF;
  logic [31:0]        s_axi_wdata = 32'h0, s_axi_rdata, r, seed = 32'h6913D63A;
  logic [14:0]        program_counter, m_pc = 15'h0000, stk[$];
  logic [33:0]        bq[$], rq[$];
  logic [46:0]        pq[$], t;
  int                 fails = 0, cmp_count = 0, cyc = 0, i;
  pcs_loader dut_u (.*);
  initial forever #5 clk_sys = ~clk_sys;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input logic [33:0] s, input logic [33:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask : check
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // one core step; expectation noted for the watcher two edges on
  task automatic step(input pcs_pkg::pcs_step_t k, input logic [10:0] op,
                      input logic [7:0] w, input logic le, input logic v);
    logic [31:0] x;
    logic [14:0] n;
    x = rnd();
    n = m_pc;
    if (v) begin
      case (k)
        pcs_pkg::STEP_ADVANCE:    n = m_pc + 15'h0001;
        pcs_pkg::STEP_WRITE_LOW:  n = {m_lat, x[7:0]};
        pcs_pkg::STEP_ADD_LOW:    n = {m_lat, 8'(m_pc[7:0] + 8'h01 + w)};
        pcs_pkg::STEP_CALL:       n = {m_lat[6:3], op};
        pcs_pkg::STEP_CALL_W:     n = {m_lat, w};
        pcs_pkg::STEP_BRANCH_W:   n = m_pc + 15'h0001 + {7'h00, w};
        pcs_pkg::STEP_BRANCH_IMM: n = m_pc + 15'h0001 + {{6{op[8]}}, op[8:0]};
        pcs_pkg::STEP_RETURN:     n = stk.pop_back();
        default:                  n = m_pc;
      endcase
      // stack keeps the newest sixteen return points
      if (k == pcs_pkg::STEP_CALL || k == pcs_pkg::STEP_CALL_W) stk.push_back(m_pc + 15'h0001);
      if (stk.size() > 16) void'(stk.pop_front());
    end
    @(posedge clk_sys);
    {step_valid, step_operand, working_value} <= {v, op, w};
    step_kind <= k;
    {latch_write_en, latch_write_data, low_write_data} <= {le, x[14:0]};
    pq.push_back({32'(cyc + 2), n});
    m_pc = n;
    if (le) m_lat = x[14:8];
  endtask : step
  // one bus write or read, held until its answer is taken
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    int n;
    if (w) bq.push_back(e);
    else rq.push_back(e);
    @(posedge clk_sys);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) break;
    end
    {s_axi_bready, s_axi_rready} <= 2'b00;
    if (n == 40) begin
      fails++;
      give_verdict();
    end
  endtask : bus
  // watchers take the oldest note whenever a result shows
  always @(negedge clk_sys) begin
    if (pq.size() > 0 && pq[0][46:15] == 32'(cyc)) begin
      t = pq.pop_front();
      check(34'(program_counter), 34'(t[14:0]));
    end
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, bq.pop_front());
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    check(34'(program_counter), 34'h0);
    reset_n <= 1'b1;
    bus(0, 8'h04, 32'h0, 34'h0);
    bus(0, 8'h08, 32'h0, 34'h1);
    bus(1, 8'h04, 32'h5A, 34'h0);
    bus(1, 8'h00, 32'hFFFFFF3C, 34'h0);
    check(34'(program_counter), 34'h5A3C);
    bus(1, 8'h0C, 32'h00007FFF, 34'h0);
    bus(0, 8'h0C, 32'h0, 34'h0);
    bus(0, 8'h00, 32'h0, 34'h3C);
    bus(1, 8'h10, 32'h1, 34'h2);
    bus(0, 8'h10, 32'h0, 34'h200000000);
    $display("register test done");
    {m_pc, m_lat} = {15'h5A3C, 7'h5A};
    step(pcs_pkg::STEP_ADVANCE, 11'h000, 8'h00, 1'b1, 1'b1);
    step(pcs_pkg::STEP_ADD_LOW, 11'h000, 8'hC2, 1'b0, 1'b1);
    step(pcs_pkg::STEP_BRANCH_IMM, 11'h100, 8'h00, 1'b0, 1'b1);
    step(pcs_pkg::STEP_BRANCH_W, 11'h000, 8'hFF, 1'b0, 1'b1);
    step(pcs_pkg::STEP_CALL, 11'h7FF, 8'h00, 1'b0, 1'b1);
    step(pcs_pkg::STEP_CALL_W, 11'h000, 8'h55, 1'b0, 1'b1);
    step(pcs_pkg::STEP_WRITE_LOW, 11'h000, 8'h00, 1'b0, 1'b1);
    step(pcs_pkg::STEP_NONE, 11'h000, 8'h00, 1'b0, 1'b0);
    bus(0, 8'h0C, 32'h0, 34'h20000);
    // a frozen clock and a stopped core must both leave the counter alone
    @(posedge clk_sys);
    {clk_en, step_valid} <= 2'b01;
    step_kind <= pcs_pkg::STEP_ADVANCE;
    repeat (3) @(posedge clk_sys);
    check(34'(program_counter), 34'(m_pc));
    {clk_en, step_valid} <= 2'b10;
    bus(1, 8'h08, 32'h0, 34'h0);
    step_valid <= 1'b1;
    bus(0, 8'h00, 32'h0, 34'(m_pc[7:0]));
    step_valid <= 1'b0;
    bus(1, 8'h08, 32'h1, 34'h0);
    $display("directed step test done");
    for (i = 0; i < 400; i++) begin
      r = rnd();
      step(pcs_pkg::pcs_step_t'(4'(r % 7) + 4'h1), r[18:8], r[26:19], r[27], r[31:29] != 3'h0);
    end
    while (stk.size() > 0) step(pcs_pkg::STEP_RETURN, 11'h000, 8'h00, 1'b0, 1'b1);
    repeat (3) step(pcs_pkg::STEP_NONE, 11'h000, 8'h00, 1'b0, 1'b0);
    $display("random step test done");
    // let the last notes reach the watcher before the counter is cleared
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(34'(program_counter), 34'h0);
    reset_n <= 1'b1;
    bus(0, 8'h0C, 32'h0, 34'h0);
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule : tb_top
